// ==== core/register_access_frame_engine.v ====
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "frame_engine_consts.vh"

module register_access_frame_engine (
  input  wire        clk_sys,     // system clock, 100 MHz
  input  wire        rst_n,       // async reset, active low
  input  wire        rx_valid,    // command byte present
  input  wire [7:0]  rx_data,     // command byte
  input  wire        rx_last,     // last byte of command frame
  output wire        rx_ready,    // engine takes command bytes
  output wire        tx_valid,    // response byte present
  output wire [7:0]  tx_data,     // response byte
  output wire        tx_last,     // last byte of response frame
  input  wire        tx_ready,    // transport takes response byte
  input  wire [7:0]  reg_addr,    // local port address
  input  wire [15:0] reg_wdata,   // local port write data
  input  wire        reg_wr,      // local port write strobe
  input  wire        reg_rd,      // local port read strobe
  output wire [15:0] reg_rdata    // local port read data
);

  localparam [2:0] S_RX    = 3'h0;
  localparam [2:0] S_CHK   = 3'h1;
  localparam [2:0] S_SCAN  = 3'h2;
  localparam [2:0] S_WRITE = 3'h3;
  localparam [2:0] S_TX    = 3'h4;

  // ==========================================================
  // checksum helpers, one byte per call, msb first
  function [15:0] crc16_byte;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg [15:0]   x;
    begin
      x = c;
      for (i = 7; i >= 0; i = i - 1) begin
        if (x[15] ^ d[i])
          x = {x[14:0], 1'b0} ^ `CRC16_POLY; // R7
        else
          x = {x[14:0], 1'b0};
      end
      crc16_byte = x;
    end
  endfunction

  function [31:0] crc32_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg [31:0]   x;
    begin
      x = c;
      for (i = 7; i >= 0; i = i - 1) begin
        if (x[31] ^ d[i])
          x = {x[30:0], 1'b0} ^ `CRC32_POLY; // R5
        else
          x = {x[30:0], 1'b0};
      end
      crc32_byte = x;
    end
  endfunction

  // ==========================================================
  // state
  reg [2:0]  state_r;
  reg [15:0] regs_r [0:63];
  reg [15:0] buf_r  [0:63];
  reg [15:0] idx_r;
  reg [7:0]  pend_r;
  reg [15:0] mark_r;
  reg [7:0]  rev_r, cmd_r, sub_r;
  reg [15:0] flags_r, start_r, hcrc_rx_r;
  reg [31:0] len_r, pcrc_rx_r;
  reg [15:0] hcrc_r;
  reg [31:0] pcrc_r;
  reg [7:0]  status_r;
  reg [6:0]  scan_r;
  reg [31:0] resp_len_r, resp_pcrc_r;
  reg        tx_valid_r, tx_last_r;
  reg [7:0]  tx_data_r;
  reg [1:0]  ctrl_r;
  reg [15:0] frames_r;
  reg [15:0] rdata_r;

  wire [15:0] pay_idx   = idx_r - `HDR_BYTES;
  wire        in_pay    = (idx_r >= `HDR_BYTES);
  wire [15:0] rx_bytes  = idx_r;               // bytes seen in frame
  wire [15:0] pay_bytes = rx_bytes - `HDR_BYTES;
  wire [6:0]  count     = len_r[7:1];
  wire [32:0] span      = {17'h0, start_r} + {1'b0, 1'b0, len_r[31:1]};
  wire [5:0]  tgt       = start_r[5:0] + scan_r[5:0];
  wire [63:0] wmask     = `WRITABLE_MASK;
  wire [15:0] mark_val  = `START_MARK;

  assign rx_ready  = (state_r == S_RX);
  assign tx_valid  = tx_valid_r;
  assign tx_data   = tx_data_r;
  assign tx_last   = tx_last_r;
  assign reg_rdata = rdata_r;

  // ==========================================================
  // frame checks, earliest failure wins; header checksum right after length and marker
  // so a corrupt header never reaches the register file
  reg [7:0] chk_status;
  always @* begin
    chk_status = `ST_OK;
    if (rx_bytes < `HDR_BYTES || mark_r != `START_MARK)
      chk_status = `ST_BAD_PACKET;                          // R1 R18
    else if (hcrc_r != hcrc_rx_r)
      chk_status = `ST_HCRC_BAD;                            // R16 R25
    else if (rev_r != `PROTO_REV)
      chk_status = `ST_BAD_REV;                             // R14
    else if (ctrl_r[`CTRL_HOLD])
      chk_status = `ST_INTERNAL;                            // R10
    else if (cmd_r != `CMD_READ && cmd_r != `CMD_WRITE)
      chk_status = `ST_UNKNOWN_CMD;                         // R18
    else if (len_r == 32'h0 || len_r[0])
      chk_status = `ST_LEN_ZERO;                            // R17
    else if (cmd_r == `CMD_READ && pay_bytes != 16'h0)
      chk_status = `ST_LEN_NONZERO;                         // R17
    else if (cmd_r == `CMD_WRITE && len_r > `PAYLOAD_MAX)
      chk_status = `ST_TOO_LONG;                            // R15
    else if (cmd_r == `CMD_WRITE && {16'h0, pay_bytes} != len_r)
      chk_status = `ST_BAD_PACKET;                          // R18
    else if (cmd_r == `CMD_WRITE && !flags_r[`FLAG_SKIP_PCRC]
             && pcrc_r != pcrc_rx_r)
      chk_status = `ST_PCRC_BAD;                            // R9 R16
    else if (start_r >= {9'h0, `REG_COUNT})
      chk_status = (cmd_r == `CMD_WRITE) ? `ST_BAD_WRITE
                                         : `ST_BAD_READ;    // R11 R12
    else if (span > `REG_COUNT_W)
      chk_status = `ST_REG_END;                             // R13
    else if (cmd_r == `CMD_WRITE && ctrl_r[`CTRL_WPROT])
      chk_status = `ST_BAD_WRITE;                           // R11
  end

  // ==========================================================
  // response byte for the current index
  reg [7:0]  tx_byte;
  wire [15:0] rword = regs_r[start_r[5:0] + pay_idx[6:1]];
  always @* begin
    tx_byte = 8'h00;
    case (idx_r)
      `OFS_MARK_HI:  tx_byte = mark_val[15:8];              // R1
      `OFS_MARK_LO:  tx_byte = mark_val[7:0];               // R1
      `OFS_REV:      tx_byte = `PROTO_REV;                  // R1
      `OFS_CMD:      tx_byte = cmd_r;                       // R2
      `OFS_SUB:      tx_byte = sub_r;
      `OFS_STATUS:   tx_byte = status_r;                    // R10
      `OFS_FLAGS_HI: tx_byte = flags_r[15:8];
      `OFS_FLAGS_LO: tx_byte = flags_r[7:0];
      `OFS_LEN_0:    tx_byte = resp_len_r[31:24];           // R3
      `OFS_LEN_1:    tx_byte = resp_len_r[23:16];
      `OFS_LEN_2:    tx_byte = resp_len_r[15:8];
      `OFS_LEN_3:    tx_byte = resp_len_r[7:0];
      `OFS_ADDR_HI:  tx_byte = start_r[15:8];               // R4
      `OFS_ADDR_LO:  tx_byte = start_r[7:0];
      `OFS_PCRC_0:   tx_byte = resp_pcrc_r[31:24];          // R5
      `OFS_PCRC_1:   tx_byte = resp_pcrc_r[23:16];
      `OFS_PCRC_2:   tx_byte = resp_pcrc_r[15:8];
      `OFS_PCRC_3:   tx_byte = resp_pcrc_r[7:0];
      `OFS_HCRC_HI:  tx_byte = hcrc_r[15:8];                // R6
      `OFS_HCRC_LO:  tx_byte = hcrc_r[7:0];
      default: begin
        if (in_pay)
          tx_byte = pay_idx[0] ? rword[7:0] : rword[15:8];  // R8
      end
    endcase
  end

  wire [15:0] tx_total = `HDR_BYTES + resp_len_r[15:0];
  wire        tx_load  = (!tx_valid_r || tx_ready) && (idx_r < tx_total);

  // ==========================================================
  // frame engine sequencer
  integer k;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= S_RX;
      idx_r       <= 16'h0;
      pend_r      <= 8'h00;
      mark_r      <= 16'h0;
      rev_r       <= 8'h00;
      cmd_r       <= 8'h00;
      sub_r       <= 8'h00;
      flags_r     <= 16'h0;
      start_r     <= 16'h0;
      hcrc_rx_r   <= 16'h0;
      len_r       <= 32'h0;
      pcrc_rx_r   <= 32'h0;
      hcrc_r      <= `CRC16_INIT;
      pcrc_r      <= `CRC32_INIT;
      status_r    <= `ST_OK;
      scan_r      <= 7'h0;
      resp_len_r  <= 32'h0;
      resp_pcrc_r <= 32'h0;
      tx_valid_r  <= 1'b0;
      tx_last_r   <= 1'b0;
      tx_data_r   <= 8'h00;
      ctrl_r      <= 2'h0;
      frames_r    <= 16'h0;
      rdata_r     <= 16'h0;
      for (k = 0; k < 64; k = k + 1) begin
        regs_r[k] <= 16'h0;
        buf_r[k]  <= 16'h0;
      end
      regs_r[0] <= `REG0_RESET; // arbitrary value, read-only slot
    end else begin
      // local port, read data valid the cycle after the strobe
      if (reg_rd) begin
        if (reg_addr < {1'b0, `REG_COUNT})
          rdata_r <= regs_r[reg_addr[5:0]];
        else if (reg_addr == `PORT_CTRL)
          rdata_r <= {14'h0, ctrl_r};
        else if (reg_addr == `PORT_STATUS)
          rdata_r <= {8'h00, status_r};
        else if (reg_addr == `PORT_FRAMES)
          rdata_r <= frames_r;
        else
          rdata_r <= 16'h0;
      end
      if (reg_wr && reg_addr == `PORT_CTRL)
        ctrl_r <= reg_wdata[1:0];

      case (state_r)
        // collect one command frame
        S_RX: begin
          if (rx_valid) begin
            if (idx_r != 16'hFFFF)
              idx_r <= idx_r + 16'h1;
            if (idx_r >= `HCRC_FIRST && idx_r <= `HCRC_LAST)
              hcrc_r <= crc16_byte(hcrc_r, rx_data);          // R6
            case (idx_r)
              `OFS_MARK_HI:  mark_r[15:8]     <= rx_data;
              `OFS_MARK_LO:  mark_r[7:0]      <= rx_data;
              `OFS_REV:      rev_r            <= rx_data;
              `OFS_CMD:      cmd_r            <= rx_data;
              `OFS_SUB:      sub_r            <= rx_data;
              `OFS_FLAGS_HI: flags_r[15:8]    <= rx_data;
              `OFS_FLAGS_LO: flags_r[7:0]     <= rx_data;
              `OFS_LEN_0:    len_r[31:24]     <= rx_data;
              `OFS_LEN_1:    len_r[23:16]     <= rx_data;
              `OFS_LEN_2:    len_r[15:8]      <= rx_data;
              `OFS_LEN_3:    len_r[7:0]       <= rx_data;
              `OFS_ADDR_HI:  start_r[15:8]    <= rx_data;
              `OFS_ADDR_LO:  start_r[7:0]     <= rx_data;
              `OFS_PCRC_0:   pcrc_rx_r[31:24] <= rx_data;
              `OFS_PCRC_1:   pcrc_rx_r[23:16] <= rx_data;
              `OFS_PCRC_2:   pcrc_rx_r[15:8]  <= rx_data;
              `OFS_PCRC_3:   pcrc_rx_r[7:0]   <= rx_data;
              `OFS_HCRC_HI:  hcrc_rx_r[15:8]  <= rx_data;
              `OFS_HCRC_LO:  hcrc_rx_r[7:0]   <= rx_data;
              default: begin
                // payload: checksum all, buffer what fits
                if (in_pay) begin
                  pcrc_r <= crc32_byte(pcrc_r, rx_data);     // R5
                  if (!pay_idx[0])
                    pend_r <= rx_data;
                  else if (pay_idx < `PAYLOAD_MAX)
                    buf_r[pay_idx[6:1]] <= {pend_r, rx_data}; // R22
                end
              end
            endcase
            if (rx_last)
              state_r <= S_CHK;                               // R23
          end
        end
        // decide outcome; failures skip all register access
        S_CHK: begin
          status_r <= chk_status;
          scan_r   <= 7'h0;
          pcrc_r   <= `CRC32_INIT;
          if (chk_status == `ST_OK)
            state_r <= S_SCAN;
          else
            state_r <= S_TX;                                  // R25
        end
        // write: check every target; read: payload checksum
        S_SCAN: begin
          if (scan_r == count) begin
            if (cmd_r == `CMD_WRITE) begin
              scan_r  <= 7'h0;
              state_r <= S_WRITE;
            end else begin
              resp_len_r  <= len_r;                           // R3
              resp_pcrc_r <= pcrc_r;                          // R5
              state_r     <= S_TX;
            end
          end else begin
            scan_r <= scan_r + 7'h1;
            if (cmd_r == `CMD_WRITE) begin
              if (!wmask[tgt]) begin
                status_r <= `ST_BAD_WRITE;                    // R11
                state_r  <= S_TX;
              end
            end else
              pcrc_r <= crc32_byte(crc32_byte(pcrc_r,
                        regs_r[tgt][15:8]), regs_r[tgt][7:0]); // R5
          end
        end
        // commit buffered words to consecutive registers
        S_WRITE: begin
          if (scan_r == count)
            state_r <= S_TX;
          else begin
            scan_r <= scan_r + 7'h1;
            // the local port wins a same-cycle clash below
            regs_r[tgt] <= buf_r[scan_r[5:0]];                // R22
          end
        end
        // stream the response; checksum rebuilt on the way out
        S_TX: begin
          if (idx_r == 16'h0 && !tx_valid_r && hcrc_r != 16'h0
              && tx_load == 1'b0)
            hcrc_r <= `CRC16_INIT;
          if (tx_load) begin
            tx_data_r  <= tx_byte;
            tx_valid_r <= 1'b1;
            tx_last_r  <= (idx_r == tx_total - 16'h1);
            idx_r      <= idx_r + 16'h1;
            if (idx_r >= `HCRC_FIRST && idx_r <= `HCRC_LAST)
              hcrc_r <= crc16_byte(hcrc_r, tx_byte);          // R6 R7
          end else if (tx_valid_r && tx_ready) begin
            tx_valid_r <= 1'b0;
            tx_last_r  <= 1'b0;
            if (tx_last_r) begin
              frames_r    <= frames_r + 16'h1;                // R23
              idx_r       <= 16'h0;
              hcrc_r      <= `CRC16_INIT;
              pcrc_r      <= `CRC32_INIT;
              resp_len_r  <= 32'h0;
              resp_pcrc_r <= 32'h0;
              state_r     <= S_RX;
            end
          end
        end
        default: state_r <= S_RX;
      endcase

      // entering transmit: restart index and header checksum
      if ((state_r == S_CHK && chk_status != `ST_OK) ||
          (state_r == S_SCAN && scan_r == count &&
           cmd_r == `CMD_READ) ||
          (state_r == S_SCAN && cmd_r == `CMD_WRITE &&
           scan_r != count && !wmask[tgt]) ||
          (state_r == S_WRITE && scan_r == count)) begin
        idx_r  <= 16'h0;
        hcrc_r <= `CRC16_INIT;
      end

      // local port writes to the register space; read-only slots
      // stay protected so software sees what frames see
      if (reg_wr && reg_addr < {1'b0, `REG_COUNT} &&
          wmask[reg_addr[5:0]])
        regs_r[reg_addr[5:0]] <= reg_wdata;
    end
  end

endmodule // register_access_frame_engine

// ==== shared/frame_engine_consts.vh ====
// Behaviour
// R1 - frames start A1EC, then version byte 03
// R2 - read response carries command code 03
// R3 - read response length holds payload byte count
// R4 - read response echoes start register index
// R5 - payload checksum is CRC-32, all-ones start
// R6 - header checksum covers bytes 02 through 3D
// R7 - header checksum is CRC-16 1021, zero start
// R8 - read values follow header, high byte first
// R9 - flags bit 0 skips payload checksum check
// R10 - status byte: 00 ok, 0D internal error
// R11 - bad or protected write target gives 0F
// R12 - bad read target gives 10
// R13 - access past last register gives 11
// R14 - unsupported protocol revision gives F9
// R15 - oversize length gives FA
// R16 - header checksum bad FB, payload bad FC
// R17 - zero length FD, unwanted length FE
// R18 - bad packet F8, unknown command FF
// R19 - host writes with command code 04
// R20 - host write length even, equals payload
// R21 - host places first target index at 0C
// R22 - write payload words land on consecutive registers
// R23 - every command frame gets exactly one response
// R24 - host read length even, half is count
// R25 - bad header checksum: no access, status only
`ifndef FRAME_ENGINE_CONSTS_VH
`define FRAME_ENGINE_CONSTS_VH

// ==========================================================
// frame layout
`define HDR_BYTES        16'h0040
`define OFS_MARK_HI      16'h0000
`define OFS_MARK_LO      16'h0001
`define OFS_REV          16'h0002
`define OFS_CMD          16'h0003
`define OFS_SUB          16'h0004
`define OFS_STATUS       16'h0005
`define OFS_FLAGS_HI     16'h0006
`define OFS_FLAGS_LO     16'h0007
`define OFS_LEN_0        16'h0008
`define OFS_LEN_1        16'h0009
`define OFS_LEN_2        16'h000A
`define OFS_LEN_3        16'h000B
`define OFS_ADDR_HI      16'h000C
`define OFS_ADDR_LO      16'h000D
`define OFS_SPARE_A      16'h000E
`define OFS_SPARE_B      16'h000F
`define OFS_PCRC_0       16'h003A
`define OFS_PCRC_1       16'h003B
`define OFS_PCRC_2       16'h003C
`define OFS_PCRC_3       16'h003D
`define OFS_HCRC_HI      16'h003E
`define OFS_HCRC_LO      16'h003F
`define HCRC_FIRST       16'h0002
`define HCRC_LAST        16'h003D

// ==========================================================
// field values
`define START_MARK       16'hA1EC
`define PROTO_REV        8'h03
`define CMD_READ         8'h03
`define CMD_WRITE        8'h04
`define FLAG_SKIP_PCRC   0

// ==========================================================
// result codes
`define ST_OK            8'h00
`define ST_INTERNAL      8'h0D
`define ST_BAD_WRITE     8'h0F
`define ST_BAD_READ      8'h10
`define ST_REG_END       8'h11
`define ST_BAD_PACKET    8'hF8
`define ST_BAD_REV       8'hF9
`define ST_TOO_LONG      8'hFA
`define ST_HCRC_BAD      8'hFB
`define ST_PCRC_BAD      8'hFC
`define ST_LEN_ZERO      8'hFD
`define ST_LEN_NONZERO   8'hFE
`define ST_UNKNOWN_CMD   8'hFF

// ==========================================================
// checksums
`define CRC16_POLY       16'h1021
`define CRC16_INIT       16'h0000
`define CRC32_POLY       32'h04C11DB7
`define CRC32_INIT       32'hFFFFFFFF

// ==========================================================
// register space and local port map
`define REG_COUNT        7'h40
`define REG_COUNT_W      33'h000000040
`define PAYLOAD_MAX      32'h00000080
`define WRITABLE_MASK    64'hFFFFFFFFFFFFFFFE
`define REG0_RESET       16'h5A00
`define PORT_CTRL        8'h40
`define PORT_STATUS      8'h41
`define PORT_FRAMES      8'h42
`define CTRL_WPROT       0
`define CTRL_HOLD        1

`endif

// ==== verif/cmd_host.sv ====
`timescale 1ns/100ps
`include "frame_engine_consts.vh"
// ==========================================================
// remote host: builds command frames, collects responses
module cmd_host (
  input  wire logic       clk_sys,   // system clock
  output logic            rx_valid,  // command byte present
  output logic [7:0]      rx_data,   // command byte
  output logic            rx_last,   // final command byte
  input  wire logic       rx_ready,  // engine takes bytes
  input  wire logic       tx_valid,  // response byte present
  input  wire logic [7:0] tx_data,   // response byte
  input  wire logic       tx_last,   // final response byte
  output logic            tx_ready   // host takes byte
);
  logic [7:0] fr [0:255];   // command frame
  logic [7:0] rsp [0:255];  // collected response
  int         rsp_n;        // response bytes collected
  logic       slow;         // drop ready every other cycle, so each response byte waits at most one cycle

  // idle lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_last  = 1'b0;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end

  // msb-first checksum steps, no reflection
  function automatic logic [15:0] c16(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {d, 8'h00};
    repeat (8) c = c[15] ? (c << 1) ^ `CRC16_POLY : c << 1;
    return c;
  endfunction
  function automatic logic [31:0] c32(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {d, 24'h000000};
    repeat (8) c = c[31] ? (c << 1) ^ `CRC32_POLY : c << 1;
    return c;
  endfunction

  // frame in wire order; bad flips a crc bit
  task automatic build(input logic [7:0] cmd, rev, input logic [15:0] flg,
                       adr, input logic [31:0] len, input int np,
                       input logic [31:0] pw, input logic [1:0] bad);
    int i;
    logic [15:0] h;
    logic [31:0] p;
    for (i = 0; i < 256; i++)
      fr[i] = 8'h00;
    {fr[0], fr[1], fr[2], fr[3]} = {`START_MARK, rev, cmd};
    {fr[6], fr[7]} = flg;
    {fr[8], fr[9], fr[10], fr[11]} = len;
    {fr[12], fr[13]} = adr;
    p = `CRC32_INIT;
    for (i = 0; i < np; i++) begin
      fr[64 + i] = pw[31 - 8 * (i % 4) -: 8];
      p = c32(p, fr[64 + i]);
    end
    {fr[58], fr[59], fr[60], fr[61]} = p ^ {31'h0, bad[1]};
    h = `CRC16_INIT;
    for (i = 2; i < 62; i++)
      h = c16(h, fr[i]);
    {fr[62], fr[63]} = h ^ {15'h0, bad[0]};
  endtask

  // frame out, response in
  task automatic exchange(input int n);
    int i;
    rsp_n = 0;
    for (i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data  <= fr[i];
      rx_last  <= (i == n - 1);
      @(posedge clk_sys iff rx_ready);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_data  <= ~fr[n - 1];  // released line must not look valid
    for (i = 0; i < 3000; i++) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      @(posedge clk_sys);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        rsp[rsp_n] = tx_data;
        rsp_n++;
        if (tx_last)
          break;
      end
    end
    tx_ready <= 1'b0;
  endtask
endmodule // cmd_host

// ==== verif/register_access_frame_engine_assertions.sv ====
`timescale 1ns/100ps
// ==========================================================
// response stream checker, top module ports only
module frame_engine_checker (
  input wire logic       clk_sys,   // system clock
  input wire logic       rst_n,     // async reset, active low
  input wire logic       rx_valid,  // command byte present
  input wire logic [7:0] rx_data,   // command byte
  input wire logic       rx_last,   // final command byte
  input wire logic       rx_ready,  // engine takes bytes
  input wire logic       tx_valid,  // response byte present
  input wire logic [7:0] tx_data,   // response byte
  input wire logic       tx_last,   // final response byte
  input wire logic       tx_ready   // host takes byte
);
  logic [7:0] tx_idx_r;  // response bytes taken so far
  logic [7:0] rx_idx_r;  // command bytes taken so far
  logic [7:0] cmd_r;     // command code of current frame

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence frame_end;
    rx_valid && rx_ready && rx_last;
  endsequence
  sequence frame_done;
    tx_valid && tx_ready && tx_last;
  endsequence

  // byte positions, restarted by each last byte
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_idx_r <= 8'h00;
      rx_idx_r <= 8'h00;
      cmd_r    <= 8'h00;
    end else begin
      if (tx_valid && tx_ready)
        tx_idx_r <= tx_last ? 8'h00 : tx_idx_r + 8'h01;
      if (rx_valid && rx_ready)
        rx_idx_r <= rx_last ? 8'h00 : rx_idx_r + 8'h01;
      if (rx_valid && rx_ready && rx_idx_r == 8'h03)
        cmd_r <= rx_data;
    end
  end

  chk_mark_high: assert property (
    tx_valid && tx_idx_r == 8'h00 |-> tx_data == 8'hA1)
    else $error("bad marker high byte");
  chk_mark_low: assert property (
    tx_valid && tx_idx_r == 8'h01 |-> tx_data == 8'hEC)
    else $error("bad marker low byte");
  chk_rev_byte: assert property (
    tx_valid && tx_idx_r == 8'h02 |-> tx_data == 8'h03)
    else $error("response revision byte wrong");
  chk_cmd_echo: assert property (
    tx_valid && tx_idx_r == 8'h03 |-> tx_data == cmd_r)
    else $error("command byte not echoed");
  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("response byte changed early");
  chk_answer_due: assert property (
    frame_end |-> ##[1:400] tx_valid)
    else $error("no response after command frame");
  chk_quiet_answer: assert property (
    tx_valid |-> !rx_ready)
    else $error("command bytes taken while answering");
  chk_reopen_rx: assert property (
    $rose(rx_ready) |-> $past(tx_valid && tx_ready && tx_last))
    else $error("receive reopened early");
  chk_full_header: assert property (
    frame_done |-> tx_idx_r >= 8'h3F)
    else $error("response shorter than a header");
endmodule // frame_engine_checker

bind register_access_frame_engine frame_engine_checker frame_engine_checker_i (
  .*);

// ==== verif/register_access_frame_engine_tb_top.sv ====
`timescale 1ns/100ps
`include "frame_engine_consts.vh"
// ==========================================================
// frame engine bench
module register_access_frame_engine_tb_top;
  logic        clk_sys, rst_n, rx_valid, rx_last, rx_ready;
  logic        tx_valid, tx_last, tx_ready, reg_wr, reg_rd;
  logic [7:0]  rx_data, tx_data, reg_addr;
  logic [15:0] reg_wdata, reg_rdata, flg;
  logic [31:0] pw;         // payload words of next frame
  int          failures;   // mismatches seen
  int          cmp_count;  // comparisons made
  int          frames;     // frames answered

  register_access_frame_engine register_access_frame_engine_i (.*);
  cmd_host cmd_host_i (.*);

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // local port strobes
  task automatic lw(input logic [7:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic lr(input logic [7:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    check(reg_rdata, e);
  endtask

  // one frame, full response check
  task automatic run(input logic [7:0] cmd, rev, input logic [15:0] adr,
                     input logic [31:0] len, input int np,
                     input logic [1:0] bad, input logic [7:0] st);
    int i;
    logic [15:0] h;
    logic [31:0] p;
    logic        rd_ok;
    logic [7:0]  r [0:255];
    cmd_host_i.build(cmd, rev, flg, adr, len, np, pw, bad);
    cmd_host_i.exchange(64 + np);
    frames++;
    r = cmd_host_i.rsp;
    rd_ok = (st == `ST_OK && cmd == `CMD_READ);
    h = `CRC16_INIT;
    p = `CRC32_INIT;
    for (i = 2; i < 62; i++)
      h = cmd_host_i.c16(h, r[i]);
    check({r[0], r[1], r[2]}, {`START_MARK, `PROTO_REV});
    check(r[3], cmd);
    check(r[5], st);
    check({r[12], r[13]}, adr);
    check({r[62], r[63]}, h);
    check(cmd_host_i.rsp_n, rd_ok ? 64 + len : 64);
    if (rd_ok) begin
      for (i = 64; i < 64 + len; i++)
        p = cmd_host_i.c32(p, r[i]);
      check({r[8], r[9], r[10], r[11]}, len);
      check({r[58], r[59], r[60], r[61]}, p);
      check({r[64], r[65], r[66], r[67]}, pw);
    end else
      check({r[8], r[9], r[10], r[11]}, 32'h0);
  endtask

  // hang guard
  initial begin
    #400000;
    failures++;
    complete_run();
  end

  // main sequence
  initial begin
    rst_n     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    flg       = 16'h0000;
    failures  = 0;
    cmp_count = 0;
    frames    = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    lr(8'h00, `REG0_RESET);
    pw = 32'h1234ABCD;
    run(`CMD_WRITE, `PROTO_REV, 16'h5, 32'h4, 4, 2'b00, `ST_OK);
    run(`CMD_READ, `PROTO_REV, 16'h5, 32'h4, 0, 2'b00, `ST_OK);
    cmd_host_i.slow = 1'b1;
    pw = 32'h55AA0F0F;
    run(`CMD_WRITE, `PROTO_REV, 16'h5, 32'h4, 4, 2'b01, `ST_HCRC_BAD);
    run(`CMD_WRITE, `PROTO_REV, 16'h5, 32'h4, 4, 2'b10, `ST_PCRC_BAD);
    pw = 32'h1234ABCD;
    run(`CMD_READ, `PROTO_REV, 16'h5, 32'h4, 0, 2'b00, `ST_OK);
    cmd_host_i.slow = 1'b0;
    flg = 16'h0001;
    pw = 32'h55AA0F0F;
    run(`CMD_WRITE, `PROTO_REV, 16'h5, 32'h4, 4, 2'b10, `ST_OK);
    flg = 16'h0000;
    run(`CMD_READ, `PROTO_REV, 16'h5, 32'h4, 0, 2'b00, `ST_OK);
    run(`CMD_READ, 8'h02, 16'h5, 32'h4, 0, 2'b00, `ST_BAD_REV);
    run(8'h07, `PROTO_REV, 16'h5, 32'h0, 0, 2'b00, `ST_UNKNOWN_CMD);
    run(`CMD_READ, `PROTO_REV, 16'h5, 32'h0, 0, 2'b00, `ST_LEN_ZERO);
    run(`CMD_READ, `PROTO_REV, 16'h5, 32'h2, 2, 2'b00, `ST_LEN_NONZERO);
    run(`CMD_WRITE, `PROTO_REV, 16'h5, 32'h100, 4, 2'b00, `ST_TOO_LONG);
    run(`CMD_WRITE, `PROTO_REV, 16'h5, 32'h4, 2, 2'b00, `ST_BAD_PACKET);
    run(`CMD_WRITE, `PROTO_REV, 16'h40, 32'h2, 2, 2'b00, `ST_BAD_WRITE);
    run(`CMD_READ, `PROTO_REV, 16'h40, 32'h2, 0, 2'b00, `ST_BAD_READ);
    run(`CMD_READ, `PROTO_REV, 16'h3F, 32'h4, 0, 2'b00, `ST_REG_END);
    run(`CMD_WRITE, `PROTO_REV, 16'h0, 32'h2, 2, 2'b00, `ST_BAD_WRITE);
    lw(8'h40, 16'h0002);
    run(`CMD_READ, `PROTO_REV, 16'h5, 32'h4, 0, 2'b00, `ST_INTERNAL);
    lw(8'h40, 16'h0001);
    run(`CMD_WRITE, `PROTO_REV, 16'h5, 32'h2, 2, 2'b00, `ST_BAD_WRITE);
    lw(8'h40, 16'h0000);
    lr(8'h41, {8'h00, `ST_BAD_WRITE});
    lw(8'h00, 16'hFFFF);
    lr(8'h00, `REG0_RESET);
    lw(8'h09, 16'hBEEF);
    lr(8'h80, 16'h0000);
    pw = 32'hBEEF0000;
    run(`CMD_READ, `PROTO_REV, 16'h9, 32'h4, 0, 2'b00, `ST_OK);
    lr(8'h42, frames[15:0]);
    complete_run();
  end
endmodule // register_access_frame_engine_tb_top
